// ### adrg_pkg.sv
// Constants for the dynamic range gain core: register map, field layout,
// reset values, level units and ramp timing.
// Assumes a 100 MHz core clock and a 24-bit two's complement sample stream.
package adrg_pkg;

   localparam int SAMPLE_W = 24;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 16;
   localparam int LEVEL_W  = 16;

   // Register offsets (index on the register port)
   localparam logic [7:0] CTRL_OFS       = 8'h28;
   localparam logic [7:0] RATE_LIMIT_OFS = 8'h29;
   localparam logic [7:0] SLOPE_OFS      = 8'h2A;
   localparam logic [7:0] KNEE_OFS       = 8'h2B;
   localparam logic [7:0] GAIN_STAT_OFS  = 8'h2C;
   localparam logic [7:0] FS_OUT_OFS     = 8'h2D;
   localparam logic [7:0] LEVEL_STAT_OFS = 8'h2E;

   // Field positions
   localparam int ENABLE_BIT   = 15;
   localparam int PATH_BIT     = 14;
   localparam int ATTACK_LSB   = 12;
   localparam int DECAY_LSB    = 8;
   localparam int FLOOR_LSB    = 2;
   localparam int CEILING_LSB  = 0;
   localparam int UP_SLOPE_LSB = 3;
   localparam int LO_SLOPE_LSB = 0;
   localparam int KNEE_IN_LSB  = 5;
   localparam int KNEE_OUT_LSB = 0;

   // Writable bits of each register
   localparam logic [15:0] CTRL_MASK       = 16'hC000;
   localparam logic [15:0] RATE_LIMIT_MASK = 16'hFF0F;
   localparam logic [15:0] SLOPE_MASK      = 16'h003F;
   localparam logic [15:0] KNEE_MASK       = 16'h07FF;

   // Reset values
   localparam logic [15:0] CTRL_RST       = 16'h0000;
   localparam logic [15:0] RATE_LIMIT_RST = 16'h3208;
   localparam logic [15:0] SLOPE_RST      = 16'h0000;
   localparam logic [15:0] KNEE_RST       = 16'h0000;

   // Levels and gains are in 1/64 dB units
   localparam int UNITS_PER_DB6   = 384;
   localparam int KNEE_STEP_UNITS = 48;
   localparam int OCTAVE_UNITS    = 193;
   localparam int LEVEL_FLOOR     = -30 * OCTAVE_UNITS;
   localparam int MS_AVG_SHIFT    = 10;
   localparam logic [2:0] UP_SLOPE_ZERO = 3'h5;
   localparam logic [2:0] LO_SLOPE_ZERO = 3'h4;

   // Ramp timing: time per 6 dB at the lowest code, then per 1/64 dB unit
   localparam int CLK_PERIOD_NS   = 10;
   localparam int ATTACK_BASE_NS  = 182000;
   localparam int DECAY_BASE_US   = 186000;
   localparam int ATTACK_STEP_CYC = (ATTACK_BASE_NS / (CLK_PERIOD_NS * UNITS_PER_DB6)) < 1 ? 1
                                   : ATTACK_BASE_NS / (CLK_PERIOD_NS * UNITS_PER_DB6);
   localparam int DECAY_STEP_CYC  = (DECAY_BASE_US * 1000) / (CLK_PERIOD_NS * UNITS_PER_DB6);

   typedef enum logic [1:0] {RAMP_HOLD, RAMP_ATTACK, RAMP_DECAY} adrg_ramp_e;

endpackage

// ### adrg_level_meter.sv
// Mean-square level meter with a log converter; level in 1/64 dB re full scale.
// Assumes sample_valid is a one-cycle strobe in the clk domain.
module adrg_level_meter
   import adrg_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic                         clk_en,
   input  wire logic                         sample_valid,
   input  wire logic [adrg_pkg::SAMPLE_W-1:0] sample,
   output logic signed [adrg_pkg::LEVEL_W-1:0] level_db
);
   import adrg_pkg::*;

   logic [31:0]        ms_reg;
   logic [15:0]        mag;
   logic [31:0]        square;
   logic signed [33:0] ms_diff;
   logic [31:0]        ms_next;
   logic [4:0]         msb;
   logic [31:0]        norm;
   logic signed [LEVEL_W-1:0] level_next;

   // Top 16 bits are enough for a level estimate and keep the square small
   assign mag     = sample[SAMPLE_W-1] ? 16'(-$signed(sample[SAMPLE_W-1:8])) : sample[SAMPLE_W-1:8];
   assign square  = mag * mag;
   assign ms_diff = $signed({2'b00, square}) - $signed({2'b00, ms_reg});
   assign ms_next = 32'($signed({2'b00, ms_reg}) + (ms_diff >>> MS_AVG_SHIFT));
   assign norm    = ms_reg << (5'd31 - msb);

   always_comb begin
      msb = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (ms_reg[i]) begin
            msb = 5'(i);
         end
      end
   end

   // Power in dB: about 193 units per octave, linear within the octave
   assign level_next = (ms_reg == 32'h0) ? 16'(LEVEL_FLOOR)
                     : 16'(($signed({27'h0, msb}) - 30) * OCTAVE_UNITS + 3 * int'(norm[30:25]));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ms_reg   <= 32'h0;
         level_db <= 16'(LEVEL_FLOOR);
      end else if (clk_en) begin
         if (sample_valid) begin
            ms_reg <= ms_next;
         end
         level_db <= level_next;
      end
   end

endmodule // adrg_level_meter

// ### adrg_gain_core.sv
// Dynamic range gain core: static two-slope curve, gain limits, RMS-driven
// attack/decay ramp and the gain multiplier on one of two sample paths.
// Assumes a 100 MHz clock, samples strobed by sample_valid, one register port.
//
// Function
// R1: The input level range is split at the knee input level, with the upper slope above it and the lower slope below it.
// R2: Slope one keeps gain constant, slopes below one compress, and slope zero holds the output level fixed.
// R3: The full-scale output level equals knee output level minus knee input level times the upper slope.
// R4: The knee input field in bits 10:5 runs from 0dB at code zero down in 0.75dB steps and resets to zero.
// R5: The knee output field in bits 4:0 runs from 0dB at code zero down in 0.75dB steps and resets to zero.
// R6: The upper slope field in bits 5:3 selects 1, 1/2, 1/4, 1/8, 1/16 or 0 and resets to 000.
// R7: The lower slope field in bits 2:0 selects 1, 1/2, 1/4, 1/8 or 0 and resets to 000.
// R8: The applied gain is clamped between the gain floor and the gain ceiling.
// R9: The gain floor field in bits 3:2 gives 0, -6, -12 or -18dB and resets to 10.
// R10: The gain ceiling field in bits 1:0 gives 12, 18, 24 or 36dB and resets to 00.
// R11: The gain loop follows the time-averaged RMS level, not single samples.
// R12: Gain falls at the attack rate while the level is high and rises at the decay rate while low.
// R13: The attack field in bits 15:12 gives 182us per 6dB at code 0001, doubling per code, reset 0011.
// R14: The decay field in bits 11:8 gives 186ms per 6dB at code 0000, doubling per code, reset 0010.
// R15: Samples are processed only when enabled, and only in the one path that the path bit selects.
// R16: Software never writes reserved codes into the knee, slope or rate fields.
//
// Our own choice: the strobed register port.
module adrg_gain_core
   import adrg_pkg::*;
#(
   parameter int DECAY_STEP_CYCLES = adrg_pkg::DECAY_STEP_CYC
)(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic                          clk_en,
   input  wire logic [adrg_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [adrg_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [adrg_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic                          sample_valid,
   input  wire logic [adrg_pkg::SAMPLE_W-1:0] adc_sample_in,
   input  wire logic [adrg_pkg::SAMPLE_W-1:0] dac_sample_in,
   output logic                               sample_out_valid,
   output logic      [adrg_pkg::SAMPLE_W-1:0] adc_sample_out,
   output logic      [adrg_pkg::SAMPLE_W-1:0] dac_sample_out,
   output logic signed [adrg_pkg::LEVEL_W-1:0] gain_level
);
   import adrg_pkg::*;

   // Slope as a right shift; the zero-slope code removes the term
   function automatic logic signed [15:0] slope_apply(input logic signed [15:0] d,
                                                     input logic [2:0] code,
                                                     input logic upper);
      logic zero;
      zero = upper ? (code == UP_SLOPE_ZERO) : (code == LO_SLOPE_ZERO);
      return zero ? 16'sh0000 : (d >>> code); // [R2] [R6] [R7]
   endfunction

   logic [15:0] ctrl_reg;
   logic [15:0] rate_limit_reg;
   logic [15:0] slope_reg;
   logic [15:0] knee_reg;
   logic [31:0] rate_cnt_reg;
   logic [31:0] rate_cnt_next;
   adrg_ramp_e  ramp_reg;
   adrg_ramp_e  ramp_next;
   logic signed [15:0] gain_next;

   wire         enable     = ctrl_reg[ENABLE_BIT];
   wire         path_dac   = ctrl_reg[PATH_BIT];
   wire [3:0]   attack_cd  = rate_limit_reg[ATTACK_LSB +: 4];
   wire [3:0]   decay_cd   = rate_limit_reg[DECAY_LSB +: 4];
   wire [1:0]   floor_cd   = rate_limit_reg[FLOOR_LSB +: 2];
   wire [1:0]   ceiling_cd = rate_limit_reg[CEILING_LSB +: 2];
   wire [2:0]   up_slope   = slope_reg[UP_SLOPE_LSB +: 3];
   wire [2:0]   lo_slope   = slope_reg[LO_SLOPE_LSB +: 3];
   wire [5:0]   knee_in_cd = knee_reg[KNEE_IN_LSB +: 6];
   wire [4:0]   knee_ou_cd = knee_reg[KNEE_OUT_LSB +: 5];

   // Register decode
   wire wr_ctrl  = reg_wr && (reg_addr == CTRL_OFS);
   wire wr_rate  = reg_wr && (reg_addr == RATE_LIMIT_OFS);
   wire wr_slope = reg_wr && (reg_addr == SLOPE_OFS);
   wire wr_knee  = reg_wr && (reg_addr == KNEE_OFS);

   // Level meter sees only the selected path, and only while enabled
   wire adc_active = enable && !path_dac; // [R15]
   wire dac_active = enable && path_dac;  // [R15]
   wire [SAMPLE_W-1:0] meter_in = path_dac ? dac_sample_in : adc_sample_in;
   wire meter_strobe = sample_valid && enable;
   logic signed [15:0] level_db;

   adrg_level_meter u_meter (
      .clk          (clk),
      .rst_b        (rst_b),
      .clk_en       (clk_en),
      .sample_valid (meter_strobe),
      .sample       (meter_in),
      .level_db     (level_db)
   ); // [R11]

   // Static curve, all in 1/64 dB units
   wire signed [15:0] knee_in_lvl  = -16'(int'(knee_in_cd) * KNEE_STEP_UNITS); // [R4]
   wire signed [15:0] knee_out_lvl = -16'(int'(knee_ou_cd) * KNEE_STEP_UNITS); // [R5]
   wire               above_knee   = level_db >= knee_in_lvl;                  // [R1]
   wire signed [15:0] upper_term   = slope_apply(level_db - knee_in_lvl, up_slope, 1'b1);
   wire signed [15:0] lower_term   = slope_apply(knee_in_lvl - level_db, lo_slope, 1'b0);
   wire signed [15:0] curve_out    = above_knee ? knee_out_lvl + upper_term
                                                : knee_out_lvl - lower_term; // [R1]
   wire signed [15:0] full_scale_output_level =
      knee_out_lvl - slope_apply(knee_in_lvl, up_slope, 1'b1); // [R3]

   // Limits: the floor stops deep cuts, the ceiling caps how far silence is boosted
   wire signed [15:0] gain_floor   = -16'(int'(floor_cd) * UNITS_PER_DB6); // [R9]
   wire signed [15:0] gain_ceiling = (ceiling_cd == 2'h3) ? 16'(6 * UNITS_PER_DB6)
                                   : 16'((int'(ceiling_cd) + 2) * UNITS_PER_DB6); // [R10]
   wire signed [15:0] raw_target   = curve_out - level_db;
   wire signed [15:0] target_gain  = (raw_target < gain_floor)   ? gain_floor
                                   : (raw_target > gain_ceiling) ? gain_ceiling
                                   : raw_target; // [R8]

   // Ramp periods per 1/64 dB; reserved attack code 0000 acts as 0001
   wire [3:0]  attack_sh   = (attack_cd == 4'h0) ? 4'h0 : attack_cd - 4'h1;
   wire [31:0] attack_per  = 32'(ATTACK_STEP_CYC) << attack_sh; // [R13]
   wire [31:0] decay_per   = 32'(DECAY_STEP_CYCLES) << decay_cd; // [R14]
   wire        want_down   = gain_level > target_gain;
   wire        want_up     = gain_level < target_gain;

   always_comb begin
      ramp_next = RAMP_HOLD;
      if (want_down) begin
         ramp_next = RAMP_ATTACK;
      end else if (want_up) begin
         ramp_next = RAMP_DECAY;
      end
   end

   // One 1/64 dB step each time the period elapses; restart on a turn
   always_comb begin
      rate_cnt_next = 32'h0;
      gain_next     = gain_level;
      case (ramp_next)
         RAMP_HOLD: begin
            rate_cnt_next = 32'h0;
         end
         RAMP_ATTACK: begin
            if (ramp_reg != RAMP_ATTACK) begin
               rate_cnt_next = 32'h0;
            end else if (rate_cnt_reg >= attack_per - 32'h1) begin
               gain_next = gain_level - 16'sh0001; // [R12]
            end else begin
               rate_cnt_next = rate_cnt_reg + 32'h1;
            end
         end
         RAMP_DECAY: begin
            if (ramp_reg != RAMP_DECAY) begin
               rate_cnt_next = 32'h0;
            end else if (rate_cnt_reg >= decay_per - 32'h1) begin
               gain_next = gain_level + 16'sh0001; // [R12]
            end else begin
               rate_cnt_next = rate_cnt_reg + 32'h1;
            end
         end
         default: begin
            rate_cnt_next = 32'h0;
         end
      endcase
   end

   // dB to linear: octaves = gain / 192.7, mantissa linear within an octave
   wire signed [23:0] oct_q6   = 24'((32'(signed'(gain_level)) * 85) >>> 8);
   wire signed [17:0] oct_int  = 18'(oct_q6 >>> 6);
   wire [6:0]         mant     = {1'b1, oct_q6[5:0]};
   wire signed [17:0] shamt_s  = 18'sd6 - oct_int;
   wire [4:0]         shamt    = (shamt_s < 0) ? 5'h00 : (shamt_s > 18'sd20) ? 5'h14 : shamt_s[4:0];
   // Product sized by the target, so the 24x8 multiply keeps all its bits
   wire signed [31:0] product  = $signed(meter_in) * $signed({1'b0, mant});
   wire signed [31:0] scaled   = product >>> shamt;
   localparam logic signed [31:0] SAT_HI = 32'sh007FFFFF;
   localparam logic signed [31:0] SAT_LO = -32'sh00800000;
   wire [SAMPLE_W-1:0] gained  = (scaled > SAT_HI) ? SAT_HI[SAMPLE_W-1:0]
                               : (scaled < SAT_LO) ? SAT_LO[SAMPLE_W-1:0]
                               : scaled[SAMPLE_W-1:0]; // Clip rather than wrap

   // Read mux; unmapped addresses read zero
   wire [15:0] rd_mux = (reg_addr == CTRL_OFS)       ? ctrl_reg
                      : (reg_addr == RATE_LIMIT_OFS) ? rate_limit_reg
                      : (reg_addr == SLOPE_OFS)      ? slope_reg
                      : (reg_addr == KNEE_OFS)       ? knee_reg
                      : (reg_addr == GAIN_STAT_OFS)  ? gain_level
                      : (reg_addr == FS_OUT_OFS)     ? full_scale_output_level
                      : (reg_addr == LEVEL_STAT_OFS) ? level_db
                      : 16'h0000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg       <= CTRL_RST;
         rate_limit_reg <= RATE_LIMIT_RST; // [R9] [R10] [R13] [R14]
         slope_reg      <= SLOPE_RST;      // [R6] [R7]
         knee_reg       <= KNEE_RST;       // [R4] [R5]
         reg_rdata      <= 16'h0000;
      end else if (clk_en) begin
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata & CTRL_MASK;
         end
         if (wr_rate) begin
            rate_limit_reg <= reg_wdata & RATE_LIMIT_MASK;
         end
         if (wr_slope) begin
            slope_reg <= reg_wdata & SLOPE_MASK;
         end
         if (wr_knee) begin
            knee_reg <= reg_wdata & KNEE_MASK;
         end
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // Gain state; held at 0 dB while the core is disabled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gain_level   <= 16'sh0000;
         rate_cnt_reg <= 32'h0;
         ramp_reg     <= RAMP_HOLD;
      end else if (clk_en) begin
         if (!enable) begin
            gain_level   <= 16'sh0000;
            rate_cnt_reg <= 32'h0;
            ramp_reg     <= RAMP_HOLD;
         end else begin
            gain_level   <= gain_next;
            rate_cnt_reg <= rate_cnt_next;
            ramp_reg     <= ramp_next;
         end
      end
   end

   // Sample paths: the unselected path passes through untouched
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sample_out_valid <= 1'b0;
         adc_sample_out   <= 24'h000000;
         dac_sample_out   <= 24'h000000;
      end else if (clk_en) begin
         sample_out_valid <= sample_valid;
         if (sample_valid) begin
            adc_sample_out <= adc_active ? gained : adc_sample_in; // [R15]
            dac_sample_out <= dac_active ? gained : dac_sample_in; // [R15]
         end
      end
   end

endmodule // adrg_gain_core

// ### adrg_gain_core_assertions.sv
// Checker for the gain core: register echo, sample bypass and gain limits.
// Assumes a bind onto adrg_gain_core; it sees only that module's ports.
module adrg_gain_core_checker
   import adrg_pkg::*;
#(
   parameter int DECAY_STEP_CYCLES = 4
)(
   input wire logic                                clk,
   input wire logic                                rst_b,
   input wire logic                                clk_en,
   input wire logic        [adrg_pkg::ADDR_W-1:0]   reg_addr,
   input wire logic        [adrg_pkg::DATA_W-1:0]   reg_wdata,
   input wire logic                                reg_wr,
   input wire logic                                reg_rd,
   input wire logic        [adrg_pkg::DATA_W-1:0]   reg_rdata,
   input wire logic                                sample_valid,
   input wire logic        [adrg_pkg::SAMPLE_W-1:0] adc_sample_in,
   input wire logic        [adrg_pkg::SAMPLE_W-1:0] dac_sample_in,
   input wire logic                                sample_out_valid,
   input wire logic        [adrg_pkg::SAMPLE_W-1:0] adc_sample_out,
   input wire logic        [adrg_pkg::SAMPLE_W-1:0] dac_sample_out,
   input wire logic signed [adrg_pkg::LEVEL_W-1:0]  gain_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  ctrl_q;
   logic [15:0] rate_q;
   logic        en_q;
   int          ceil_u;
   int          floor_u;
   assign en_q    = ctrl_q[1];
   assign ceil_u  = (rate_q[1:0] == 2'h3) ? 2304 : 768 + 384 * int'(rate_q[1:0]);
   assign floor_u = -384 * int'(rate_q[3:2]);
   // Shadow copy of the two control words, so limits are known here
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 2'h0;
         rate_q <= 16'h3208;
      end else if (clk_en && reg_wr && reg_addr == CTRL_OFS) begin
         ctrl_q <= reg_wdata[15:14];
      end else if (clk_en && reg_wr && reg_addr == RATE_LIMIT_OFS) begin
         rate_q <= reg_wdata & 16'hFF0F;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ctrl_readback: assert property (reg_rd && reg_addr == CTRL_OFS
      |=> reg_rdata == {$past(ctrl_q), 14'h0}) else $error("control read mismatch");
   a_rate_readback: assert property (reg_rd && reg_addr == RATE_LIMIT_OFS
      |=> reg_rdata == $past(rate_q)) else $error("rate read mismatch");
   a_valid_delay: assert property (sample_out_valid == $past(sample_valid))
      else $error("output strobe not one cycle after input strobe");
   a_adc_bypass: assert property (sample_valid && ctrl_q != 2'b10
      |=> adc_sample_out == $past(adc_sample_in)) else $error("adc path altered");
   a_dac_bypass: assert property (sample_valid && ctrl_q != 2'b11
      |=> dac_sample_out == $past(dac_sample_in)) else $error("dac path altered");
   a_output_hold: assert property (!sample_valid
      |=> $stable(adc_sample_out) && $stable(dac_sample_out)) else $error("outputs moved");
   a_gain_off: assert property (!en_q [*2] |-> gain_level == 16'sh0)
      else $error("gain not neutral while disabled");
   a_gain_ceiling: assert property (gain_level > ceil_u
      |=> gain_level <= $past(gain_level)) else $error("gain rose above ceiling");
   a_gain_floor: assert property (gain_level < floor_u
      |=> gain_level >= $past(gain_level)) else $error("gain fell below floor");
   a_gain_step: assert property (en_q && $past(en_q) |-> (gain_level == $past(gain_level))
      || (gain_level == $past(gain_level) + 16'sh1) || (gain_level == $past(gain_level) - 16'sh1))
      else $error("gain jumped");
   c_fs_read: cover property (reg_rd && reg_addr == FS_OUT_OFS);
   c_ceiling: cover property (en_q && gain_level == ceil_u);
   c_floor: cover property (en_q && gain_level == floor_u && floor_u < 0);
endmodule // adrg_gain_core_checker

// ### adrg_sample_src.sv
// Sample path model: strobes ADC and DAC samples into the gain core.
// Assumes mode, slow and noise come from the bench; mode 0 idle,
// 1 silence, 2 full-scale square wave, 3 noise.
module adrg_sample_src
   import adrg_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic [1:0]                    mode,
   input  wire logic                          slow,
   input  wire logic [adrg_pkg::SAMPLE_W-1:0] noise,
   output logic                               sample_valid,
   output logic      [adrg_pkg::SAMPLE_W-1:0] adc_sample,
   output logic      [adrg_pkg::SAMPLE_W-1:0] dac_sample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] gap;
   logic       sign;
   // Data keep moving between strobes, so a core that samples late is seen
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap <= 2'h0;
         sign <= 1'b0;
         sample_valid <= 1'b0;
         adc_sample <= 24'h000000;
         dac_sample <= 24'h000000;
      end else begin
         gap <= (gap != 2'h0) ? gap - 2'h1 : (slow ? 2'h2 : 2'h0);
         sample_valid <= (mode != 2'h0) && (gap == 2'h0);
         sign <= ~sign;
         adc_sample <= (mode == 2'h1) ? 24'h0 : (mode == 2'h2) ? (sign ? 24'h800001 : 24'h7FFFFF) : noise;
         dac_sample <= (mode == 2'h1) ? 24'h0 : (mode == 2'h2) ? (sign ? 24'h7FFFFF : 24'h800001) : ~noise;
      end
   end
endmodule // adrg_sample_src

// ### test_audio_dynamic_range_gain_core.sv
// Self-checking bench: register map, bypass of the idle path, gain ramps and limits.
// Assumes adrg_pkg, the core, the sample source and the checker are compiled first.
module test_audio_dynamic_range_gain_core;
   timeunit 1ns;
   timeprecision 1ps;
   import adrg_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic        slow = 1'b0;
   logic        keep_adc = 1'b1;
   logic        keep_dac = 1'b1;
   logic [31:0] lfsr = 32'hAF1F;
   logic [23:0] noise = 24'h000000;
   logic [15:0] reg_rdata;
   logic        sample_valid, out_valid;
   logic [23:0] adc_in, dac_in, adc_out, dac_out;
   logic signed [15:0] gain_level;
   logic [23:0] adc_q[$];
   logic [23:0] dac_q[$];
   int          miscompares = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          n, ki, ko, fs;
   adrg_gain_core #(.DECAY_STEP_CYCLES(4)) uut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample_valid(sample_valid), .adc_sample_in(adc_in),
      .dac_sample_in(dac_in), .sample_out_valid(out_valid), .adc_sample_out(adc_out),
      .dac_sample_out(dac_out), .gain_level(gain_level));
   adrg_sample_src src (.clk(clk), .rst_b(rst_b), .mode(mode), .slow(slow), .noise(noise),
      .sample_valid(sample_valid), .adc_sample(adc_in), .dac_sample(dac_in));
   always #5 clk = ~clk;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_smp(input string nm, input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_val(input string nm, input logic signed [31:0] e, input logic signed [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk_reg("reg_rdata", e, reg_rdata);
   endtask
   // Drain the stream before switching, so no sample straddles a mode change
   task automatic path_run(input logic [15:0] c, input logic ka, input logic kd);
      mode <= 2'h0;
      repeat (4) @(posedge clk);
      wr(CTRL_OFS, c);
      keep_adc <= ka;
      keep_dac <= kd;
      mode <= 2'h3;
      repeat (300) @(posedge clk);
   endtask
   task automatic wait_gain(input logic signed [15:0] t, input int lim);
      n = 0;
      while (gain_level !== t && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk_val("gain_level", t, gain_level);
   endtask
   always @(posedge clk) begin
      lfsr <= lfsr_next(lfsr);
      noise <= lfsr[23:0];
      slow <= lfsr[5];
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         miscompares++;
         complete_run();
      end
   end
   always @(negedge clk) begin
      if (out_valid && adc_q.size() > 0) begin
         if (keep_adc) chk_smp("adc_sample_out", adc_q[0], adc_out);
         if (keep_dac) chk_smp("dac_sample_out", dac_q[0], dac_out);
         adc_q.delete(0);
         dac_q.delete(0);
      end
      if (sample_valid) begin
         adc_q.push_back(adc_in);
         dac_q.push_back(dac_in);
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(CTRL_OFS, 16'h0000);
      rd(RATE_LIMIT_OFS, 16'h3208);
      rd(SLOPE_OFS, 16'h0000);
      rd(KNEE_OFS, 16'h0000);
      wr(RATE_LIMIT_OFS, 16'hA8FF);
      rd(RATE_LIMIT_OFS, 16'hA80F);
      wr(CTRL_OFS, 16'h3FFF);
      rd(CTRL_OFS, 16'h0000);
      wr(8'h30, 16'hFFFF);
      rd(8'h30, 16'h0000);
      for (int s = 0; s < 6; s++) begin
         ki = (s == 0) ? 60 : int'(lfsr % 61);
         ko = (s == 0) ? 30 : int'(lfsr % 31);
         fs = (s == 5) ? -48 * ko : ((48 * ki) >> s) - 48 * ko;
         wr(SLOPE_OFS, 16'((s << 3) | (s < 5 ? s : 4)) | 16'hFFC0);
         wr(KNEE_OFS, 16'((ki << 5) | ko));
         rd(KNEE_OFS, 16'((ki << 5) | ko));
         rd(SLOPE_OFS, 16'((s << 3) | (s < 5 ? s : 4)));
         rd(FS_OUT_OFS, 16'(fs));
      end
      path_run(16'h0000, 1'b1, 1'b1);
      path_run(16'h8000, 1'b0, 1'b1);
      path_run(16'hC000, 1'b1, 1'b0);
      path_run(16'h0000, 1'b0, 1'b1);
      mode <= 2'h1;
      wr(SLOPE_OFS, 16'h0004);
      // Deep knee: target clamps to the ceiling whatever level the meter still holds
      wr(KNEE_OFS, 16'h0780);
      wr(RATE_LIMIT_OFS, 16'h1005);
      wr(CTRL_OFS, 16'h8000);
      wait_gain(16'sd1152, 8000);
      chk_val("decay_time", 72, n / 64);
      wr(RATE_LIMIT_OFS, 16'h1004);
      wait_gain(16'sd768, 25000);
      chk_val("attack_time", 1, n >= 384 * 47);
      wr(CTRL_OFS, 16'h0000);
      mode <= 2'h2;
      repeat (8000) @(posedge clk);
      wr(KNEE_OFS, 16'h001E);
      wr(RATE_LIMIT_OFS, 16'h1005);
      wr(CTRL_OFS, 16'h8000);
      wait_gain(-16'sd384, 40000);
      chk_val("attack_time", 1, n >= 384 * 47);
      wr(RATE_LIMIT_OFS, 16'h1001);
      wait_gain(16'sd0, 20000);
      repeat (200) @(negedge clk);
      chk_val("gain_hold", 0, gain_level);
      complete_run();
   end
endmodule // test_audio_dynamic_range_gain_core
bind adrg_gain_core adrg_gain_core_checker #(.DECAY_STEP_CYCLES(DECAY_STEP_CYCLES)) chk_i (
   .clk, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_valid,
   .adc_sample_in, .dac_sample_in, .sample_out_valid, .adc_sample_out, .dac_sample_out,
   .gain_level);
